// *** shared/mdfr_params.svh ***
`ifndef MDFR_PARAMS_SVH
`define MDFR_PARAMS_SVH
// Clock period and cycle rounding
`define MDFR_CLK_NS        40
`define MDFR_CYC_UP(ns)    (((ns) + `MDFR_CLK_NS - 1) / `MDFR_CLK_NS)
// Register byte offsets
`define MDFR_ADDR_CFG      12'h000
`define MDFR_ADDR_CMD      12'h004
`define MDFR_ADDR_STAT     12'h008
// Configuration fields
`define MDFR_CFG_OV_EN     0
`define MDFR_CFG_OV_SEL    1
`define MDFR_CFG_OC_MODE   3:2
`define MDFR_CFG_OC_DEG    5:4
`define MDFR_CFG_RETRY     6
`define MDFR_CFG_THERMAL_WARNING_REPORT_ENABLE   7
`define MDFR_CFG_SAT_EN    8
`define MDFR_CFG_BCL_EN    9
`define MDFR_CFG_WIDTH     10
`define MDFR_CFG_RESET     10'h001
// Command field
`define MDFR_CMD_CLR       0
// Overcurrent mode codes
`define MDFR_OC_LATCH      2'h0
`define MDFR_OC_RETRY      2'h1
`define MDFR_OC_REPORT     2'h2
`define MDFR_OC_OFF        2'h3
// Deglitch times in ns, one per select code
`define MDFR_DEG0_NS       200
`define MDFR_DEG1_NS       600
`define MDFR_DEG2_NS       1000
`define MDFR_DEG3_NS       1600
// Retry times in ns, one per select code
`define MDFR_RETRY0_NS     5000000
`define MDFR_RETRY1_NS     500000000
`endif

// *** shared/mdfr_pkg.sv ***
package mdfr_pkg;
  // Overcurrent response state, one-hot
  typedef enum logic [2:0] {
    MDFR_OC_RUN   = 3'b001,
    MDFR_OC_HOLD  = 3'b010,
    MDFR_OC_WAIT  = 3'b100
  } mdfr_oc_state_t;
endpackage : mdfr_pkg

// *** sim/mdfr_ctrl_model.sv ***
`timescale 1ns/1ps
// External controller: APB master, watches the fault pin
module mdfr_ctrl_model (
  input  wire logic        clk_sys,
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic      [11:0] paddr,
  output logic      [31:0] pwdata,
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr,
  input  wire logic        fault_out_n,
  input  wire logic        fet_enable
);
  logic handled_q;
  // Idle bus at time zero
  initial begin
    {psel, penable, pwrite, paddr, pwdata, handled_q} = '0;
  end
  // One transfer, request held until pready is sampled
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d,
           output logic [31:0] r, output logic e);
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do @(posedge clk_sys); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  always @(posedge clk_sys) begin
    if (fault_out_n === 1'b0 && fet_enable === 1'b1) begin
      handled_q <= 1'b1;
    end
  end
endmodule : mdfr_ctrl_model

// *** sim/motor_driver_fault_response_test.sv ***
`timescale 1ns/1ps
module motor_driver_fault_response_test;
  import mdfr_pkg::*;
  logic clk_sys, rst, psel, penable, pwrite, pready, pslverr, er;
  logic fault_out_n, fet_enable, charge_pump_enable;
  logic buck_enable, device_reset_req, speed_limit;
  logic [11:0] paddr, det;
  logic [31:0] pwdata, prdata, rd, fb;
  logic [5:0] foc, o, oe;
  int bad_count, checks_done, cycles, k;
  assign o = {fault_out_n, fet_enable, charge_pump_enable, buck_enable,
              device_reset_req, speed_limit};
  // Device and controller
  mdfr_fault_response #(.RETRY0_CYC(60), .RETRY1_CYC(120)) dut (
    .clk_sys, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .vm_undervoltage(det[0]),
    .analog_rail_undervoltage(det[1]), .buck_rail_undervoltage(det[2]),
    .buck_overcurrent(det[3]), .charge_pump_low_event(det[4]),
    .vm_above_22v(det[5]), .vm_above_34v(det[6]),
    .bus_current_over(det[7]), .current_loop_sat(det[8]),
    .speed_loop_sat(det[9]), .thermal_warning(det[10]),
    .thermal_shutdown(det[11]), .fet_overcurrent(foc), .fault_out_n,
    .fet_enable, .charge_pump_enable, .buck_enable, .device_reset_req,
    .speed_limit);
  mdfr_ctrl_model ctrl (.clk_sys, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .fault_out_n, .fet_enable);
  // Clock and hang limit
  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      bad_count++;
      give_verdict();
    end
  end
  ////////////////////////////////////////
  // Helpers
  task give_verdict();
    $display("checks %0d bad %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : give_verdict
  task cyc(input int n);
    repeat (n) @(posedge clk_sys);
  endtask : cyc
  task chk(input string n, input logic [31:0] e, input logic [31:0] s);
    checks_done++;
    if (s !== e) begin
      bad_count++;
      $display("BAD %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task rg(input logic w, input logic [11:0] a, input logic [31:0] d);
    ctrl.apb(w, a, d, rd, er);
  endtask : rg
  task st(input logic [31:0] m, input logic [31:0] v);
    rg(1'b0, 12'h008, 32'h0);
    chk("status", v & m, rd & m);
  endtask : st
  task outs(input logic [5:0] m, input logic [5:0] v);
    #1;
    chk("outputs", {26'h0, v & m}, {26'h0, o & m});
  endtask : outs
  task drive(input logic [11:0] d);
    @(posedge clk_sys);
    det <= d;
    cyc(14);
  endtask : drive
  // Fault present, clear refused, released, cleared
  task sc(input logic [11:0] d, input logic [9:0] c, input logic [5:0] om,
          input logic [5:0] ov, input logic [31:0] sm, input logic [31:0] sv,
          input logic [31:0] sa);
    rg(1'b1, 12'h000, {22'h0, c});
    drive(d);
    outs(om, ov);
    st(sm, sv);
    rg(1'b1, 12'h004, 32'h1);
    st(sa, sa);
    drive(12'h0);
    outs(6'h31, 6'h30);
    st(sa, sa);
    rg(1'b1, 12'h004, 32'h1);
    st(sm, 32'h0);
  endtask : sc
  // Main sequence
  initial begin
    rst = 1'b1;
    det = '0;
    foc = '0;
    {bad_count, checks_done, cycles} = '0;
    void'($urandom(32'h1B8F338D));
    cyc(16);
    rst <= 1'b0;
    cyc(3);
    outs(6'h3F, 6'h3C);
    rg(1'b0, 12'h000, 32'h0);
    chk("cfg", 32'h1, rd);
    rg(1'b0, 12'h010, 32'h0);
    chk("slverr", 32'h1, {31'h0, er});
    rg(1'b1, 12'h008, 32'hFFFFFFFF);
    st(32'h1FFFF, 32'h0);
    sc(12'h010, 10'h001, 6'h30, 6'h00, 32'h3, 32'h3, 32'h2);
    sc(12'h020, 10'h001, 6'h30, 6'h00, 32'h5, 32'h5, 32'h4);
    sc(12'h020, 10'h003, 6'h30, 6'h30, 32'h5, 32'h0, 32'h0);
    sc(12'h060, 10'h003, 6'h30, 6'h00, 32'h5, 32'h5, 32'h4);
    sc(12'h060, 10'h000, 6'h30, 6'h30, 32'h5, 32'h0, 32'h0);
    sc(12'h800, 10'h001, 6'h38, 6'h00, 32'h801, 32'h801, 32'h800);
    sc(12'h400, 10'h001, 6'h30, 6'h30, 32'h401, 32'h0, 32'h0);
    sc(12'h400, 10'h081, 6'h30, 6'h10, 32'h400, 32'h400, 32'h400);
    sc(12'h080, 10'h201, 6'h31, 6'h11, 32'h9000, 32'h9000, 32'h0);
    sc(12'h080, 10'h001, 6'h31, 6'h30, 32'h9000, 32'h0, 32'h0);
    sc(12'h100, 10'h101, 6'h30, 6'h10, 32'hA000, 32'hA000, 32'h0);
    sc(12'h200, 10'h101, 6'h30, 6'h10, 32'hC000, 32'hC000, 32'h0);
    for (int m = 0; m < 4; m++) begin
      k = $urandom_range(5, 0);
      fb = 32'h1 << (4 + k);
      oe = (m == 3) ? 6'h30 : (m == 2) ? 6'h10 : 6'h00;
      rg(1'b1, 12'h000, 32'h1 | (m << 2));
      @(posedge clk_sys);
      foc <= 6'h1 << k;
      cyc(3);
      foc <= 6'h0;
      cyc(14);
      st(32'h3F9, 32'h0);
      @(posedge clk_sys);
      foc <= 6'h1 << k;
      cyc(16);
      outs(6'h30, oe);
      st(32'h3F9, (m == 3) ? 32'h0 : 32'h9 | fb);
      @(posedge clk_sys);
      foc <= 6'h0;
      cyc(70);
      outs(6'h30, (m == 1) ? 6'h30 : oe);
      st(32'h3F9, (m == 3) ? 0 : (m == 1) ? 8 | fb : 9 | fb);
      rg(1'b1, 12'h004, 32'h1);
      cyc(8);
      outs(6'h30, 6'h30);
      st(32'h3F9, 32'h0);
    end
    for (int i = 0; i < 4; i++) begin
      drive(12'h1 << i);
      outs((i < 2) ? 6'h1A : 6'h06, 6'h02);
      st(32'h10000, 32'h10000);
      drive(12'h0);
      outs((i < 3) ? 6'h1E : 6'h04, (i < 3) ? 6'h1C : 6'h00);
    end
    @(posedge clk_sys);
    rst <= 1'b1;
    cyc(2);
    rst <= 1'b0;
    cyc(3);
    outs(6'h3F, 6'h3C);
    chk("handled", 32'h1, {31'h0, ctrl.handled_q});
    give_verdict();
  end
endmodule : motor_driver_fault_response_test

// *** src/mdfr_fault_response.sv ***
`timescale 1ns/1ps
`include "mdfr_params.svh"
// Behaviour
// - bus current limit reports, restricts, self-releases
// - loop saturation reported, outputs keep switching
// - main supply undervoltage forces reset, FETs and pump off, buck stays on
// - analog rail undervoltage forces reset, FETs and pump off, buck stays on
// - buck undervoltage stops buck, forces reset
// - charge pump low: FETs off, sticky bit
// - overvoltage: FETs off, sticky bit
// - overvoltage enable low disables protection
// - select bit picks 22 or 34 volt
// - overcurrent needs deglitch time, then mode
// - mode 00 latches until a clear command with overcurrent gone
// - mode 01 retries after retry time
// - mode 10 reports only, bits sticky
// - mode 11 ignores overcurrent entirely
// - buck overcurrent stops buck, forces reset
// - thermal warning reported only when enabled
// - thermal shutdown: FETs, pump off, sticky
module mdfr_fault_response
  import mdfr_pkg::*;
#(
  parameter int unsigned RETRY0_CYC = `MDFR_RETRY0_NS / `MDFR_CLK_NS,
  parameter int unsigned RETRY1_CYC = `MDFR_RETRY1_NS / `MDFR_CLK_NS
) (
  input  wire logic        clk_sys,
  input  wire logic        rst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        vm_undervoltage,
  input  wire logic        analog_rail_undervoltage,
  input  wire logic        buck_rail_undervoltage,
  input  wire logic        buck_overcurrent,
  input  wire logic        charge_pump_low_event,
  input  wire logic        vm_above_22v,
  input  wire logic        vm_above_34v,
  input  wire logic        bus_current_over,
  input  wire logic        current_loop_sat,
  input  wire logic        speed_loop_sat,
  input  wire logic        thermal_warning,
  input  wire logic        thermal_shutdown,
  input  wire logic [5:0]  fet_overcurrent,
  output logic             fault_out_n,
  output logic             fet_enable,
  output logic             charge_pump_enable,
  output logic             buck_enable,
  output logic             device_reset_req,
  output logic             speed_limit
);

  localparam int NIN = 18;
  localparam logic [6:0] DEG_CYC [4] = '{
    7'(`MDFR_CYC_UP(`MDFR_DEG0_NS)), 7'(`MDFR_CYC_UP(`MDFR_DEG1_NS)),
    7'(`MDFR_CYC_UP(`MDFR_DEG2_NS)), 7'(`MDFR_CYC_UP(`MDFR_DEG3_NS))};

  // Retry counter is 24 bits wide
  if (RETRY0_CYC == 0 || RETRY1_CYC == 0 ||
      RETRY0_CYC >= 32'h0100_0000 || RETRY1_CYC >= 32'h0100_0000) begin : g_chk
    $error("retry counts must be 1 to 2**24-1");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Input synchronisers
  logic [NIN-1:0] raw, s1_q, s2_q, s3_q, in_q;
  assign raw = {fet_overcurrent, thermal_shutdown, thermal_warning,
                speed_loop_sat, current_loop_sat, bus_current_over,
                vm_above_34v, vm_above_22v, charge_pump_low_event,
                buck_overcurrent, buck_rail_undervoltage,
                analog_rail_undervoltage, vm_undervoltage};

  // Three stages; a change is taken once stages two and three agree
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
      in_q <= '0;
    end else begin
      s1_q <= raw;
      s2_q <= s1_q;
      s3_q <= s2_q;
      for (int i = 0; i < NIN; i++) begin
        if (s2_q[i] == s3_q[i]) begin
          in_q[i] <= s3_q[i];
        end
      end
    end
  end

  logic       s_vm, s_avdd, s_bkuv, s_bkoc, s_cp, s_ov22, s_ov34;
  logic       s_bcl, s_csat, s_ssat, s_otw, s_tsd;
  logic [5:0] s_foc;
  assign {s_foc, s_tsd, s_otw, s_ssat, s_csat, s_bcl, s_ov34, s_ov22,
          s_cp, s_bkoc, s_bkuv, s_avdd, s_vm} = in_q;

  ////////////////////////////////////////////////////////////////////////////
  // APB slave
  logic [`MDFR_CFG_WIDTH-1:0] cfg_q;
  logic [31:0]                status;
  logic                       clr_cmd;
  logic                       hit_cfg, hit_cmd, hit_stat, mapped;

  assign hit_cfg  = paddr == `MDFR_ADDR_CFG;
  assign hit_cmd  = paddr == `MDFR_ADDR_CMD;
  assign hit_stat = paddr == `MDFR_ADDR_STAT;
  assign mapped   = hit_cfg | hit_cmd | hit_stat;
  assign pready   = 1'b1;                     // Zero wait states
  assign pslverr  = psel & penable & ~mapped; // Unmapped address
  assign clr_cmd  = psel & penable & pwrite & hit_cmd
                    & pwdata[`MDFR_CMD_CLR];

  // Configuration register
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      cfg_q <= `MDFR_CFG_RESET;
    end else if (psel && penable && pwrite && hit_cfg) begin
      cfg_q <= pwdata[`MDFR_CFG_WIDTH-1:0];
    end
  end

  // Read data captured in the setup cycle
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      prdata <= '0;
    end else if (psel && !penable && !pwrite) begin
      prdata <= hit_cfg  ? {22'h0, cfg_q} :
                hit_stat ? status : 32'h0;
    end
  end

  logic       ov_en, ov_sel, thermal_warning_report_enable, sat_en, bcl_en, retry_sel;
  logic [1:0] oc_mode;
  assign ov_en     = cfg_q[`MDFR_CFG_OV_EN];
  assign ov_sel    = cfg_q[`MDFR_CFG_OV_SEL];
  assign oc_mode   = cfg_q[`MDFR_CFG_OC_MODE];
  assign retry_sel = cfg_q[`MDFR_CFG_RETRY];
  assign thermal_warning_report_enable   = cfg_q[`MDFR_CFG_THERMAL_WARNING_REPORT_ENABLE];
  assign sat_en    = cfg_q[`MDFR_CFG_SAT_EN];
  assign bcl_en    = cfg_q[`MDFR_CFG_BCL_EN];

  ////////////////////////////////////////////////////////////////////////////
  // Live fault conditions
  logic ov_act, bcl_act, sat_act, otw_act, rst_cond, buck_off;
  assign ov_act   = ov_en & (ov_sel ? s_ov34 : s_ov22);
  assign bcl_act  = bcl_en & s_bcl;
  assign sat_act  = sat_en & (s_csat | s_ssat);
  assign otw_act  = thermal_warning_report_enable & s_otw;

  ////////////////////////////////////////////////////////////////////////////
  // Deglitch counters for FET and buck overcurrent
  logic [6:0] oc_cnt_q, bk_cnt_q, deg;
  logic       oc_hit, bk_hit_q;
  assign deg    = DEG_CYC[cfg_q[`MDFR_CFG_OC_DEG]];
  assign oc_hit = (|s_foc) && (oc_cnt_q == deg);

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      oc_cnt_q <= '0;
    end else if (!(|s_foc)) begin
      oc_cnt_q <= '0;
    end else if (oc_cnt_q != deg) begin
      oc_cnt_q <= oc_cnt_q + 7'h01;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      bk_cnt_q <= '0;
      bk_hit_q <= 1'b0;
    end else if (!s_bkoc) begin
      bk_cnt_q <= '0;
    end else if (bk_cnt_q != deg) begin
      bk_cnt_q <= bk_cnt_q + 7'h01;
    end else begin
      bk_hit_q <= 1'b1;
    end
  end

  assign rst_cond = s_vm | s_avdd | s_bkuv | bk_hit_q;
  assign buck_off = s_bkuv | bk_hit_q;

  ////////////////////////////////////////////////////////////////////////////
  // Overcurrent response state machine
  mdfr_oc_state_t oc_st_q;
  logic [23:0]    retry_q;
  logic           oc_event;
  assign oc_event = oc_hit && oc_mode != `MDFR_OC_OFF;

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      oc_st_q <= MDFR_OC_RUN;
      retry_q <= '0;
    end else begin
      unique case (oc_st_q)
        MDFR_OC_RUN: begin
          if (oc_event && oc_mode == `MDFR_OC_LATCH) begin
            oc_st_q <= MDFR_OC_HOLD;
          end else if (oc_event && oc_mode == `MDFR_OC_RETRY) begin
            oc_st_q <= MDFR_OC_WAIT;
            retry_q <= retry_sel ? 24'(RETRY1_CYC - 1)
                                 : 24'(RETRY0_CYC - 1);
          end
        end
        MDFR_OC_HOLD: begin
          if (clr_cmd && !(|s_foc)) begin
            oc_st_q <= MDFR_OC_RUN;
          end
        end
        MDFR_OC_WAIT: begin
          if (retry_q == 24'h0) begin
            oc_st_q <= MDFR_OC_RUN;
          end else begin
            retry_q <= retry_q - 24'h1;
          end
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sticky status bits; a set beats a clear in the same cycle
  logic       cp_q, ov_q, oc_q, rep_q, otw_q, ots_q;
  logic [5:0] foc_q;

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      cp_q  <= 1'b0;
      ov_q  <= 1'b0;
      otw_q <= 1'b0;
      ots_q <= 1'b0;
    end else begin
      cp_q  <= s_cp   | (cp_q  & ~clr_cmd);
      ov_q  <= ov_act | (ov_q  & ~clr_cmd);
      ots_q <= s_tsd  | (ots_q & ~clr_cmd);
      otw_q <= otw_act | (otw_q & ~(clr_cmd & ~s_otw));
    end
  end

  // overcurrent flags, cleared only with condition gone
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      oc_q  <= 1'b0;
      rep_q <= 1'b0;
      foc_q <= '0;
    end else if (oc_event) begin
      oc_q  <= 1'b1;
      rep_q <= rep_q | (oc_mode == `MDFR_OC_REPORT);
      foc_q <= foc_q | s_foc;
    end else if (clr_cmd && !(|s_foc)) begin
      oc_q  <= 1'b0;
      rep_q <= 1'b0;
      foc_q <= '0;
    end
  end

  logic drv_fault, ctl_fault;
  // driver fault drops when retry ends
  assign drv_fault = s_cp | ov_act | s_tsd | rep_q
                     | (oc_st_q != MDFR_OC_RUN);
  assign ctl_fault = bcl_act | sat_act;
  assign status = {15'h0, rst_cond, ctl_fault, s_ssat & sat_en,
                   s_csat & sat_en, bcl_act, ots_q, otw_q, foc_q,
                   oc_q, ov_q, cp_q, drv_fault};

  ////////////////////////////////////////////////////////////////////////////
  // Output stage, all registered
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      fault_out_n        <= 1'b1;
      fet_enable         <= 1'b0;
      charge_pump_enable <= 1'b0;
      buck_enable        <= 1'b0;
      device_reset_req   <= 1'b0;
      speed_limit        <= 1'b0;
    end else begin
      fault_out_n        <= ~(drv_fault | ctl_fault | otw_act);
      fet_enable         <= ~(rst_cond | drv_fault) | (rep_q & ~s_cp
                            & ~ov_act & ~s_tsd & oc_st_q == MDFR_OC_RUN
                            & ~rst_cond);
      charge_pump_enable <= ~(rst_cond | s_tsd);
      buck_enable        <= ~buck_off;
      device_reset_req   <= rst_cond;
      speed_limit        <= bcl_act;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Assertions
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  reset_on_supply_a: assert property (s_vm || s_avdd |=> device_reset_req
    && !fet_enable && !charge_pump_enable)
    else $error("supply undervoltage did not force reset");
  buck_rail_undervoltage_off_a: assert property (s_bkuv |=> !buck_enable
    && device_reset_req)
    else $error("buck undervoltage left buck running");
  cp_low_fault_a: assert property (s_cp |=> !fet_enable && !fault_out_n
    && cp_q)
    else $error("charge pump low not acted on");
  ov_disabled_a: assert property (!ov_en |=> !$rose(ov_q))
    else $error("overvoltage flagged while disabled");
  ov_select_a: assert property (ov_en && !ov_sel && s_ov22 |=> ov_q
    && !fet_enable)
    else $error("22 volt trip missed");
  oc_deglitch_a: assert property ($rose(oc_q) |->
    $past(oc_cnt_q) == $past(deg))
    else $error("overcurrent taken before deglitch");
  oc_latch_hold_a: assert property (oc_st_q == MDFR_OC_HOLD && !clr_cmd
    |=> oc_st_q == MDFR_OC_HOLD)
    else $error("latched overcurrent released without clear");
  oc_retry_end_a: assert property (oc_st_q == MDFR_OC_WAIT
    && retry_q == 24'h0 |=> oc_st_q == MDFR_OC_RUN ##0 oc_q)
    else $error("retry did not resume");
  oc_report_run_a: assert property (oc_event && oc_mode ==
    `MDFR_OC_REPORT && oc_st_q == MDFR_OC_RUN |=> oc_st_q == MDFR_OC_RUN
    && rep_q)
    else $error("report mode changed drive state");
  oc_off_quiet_a: assert property (oc_mode == `MDFR_OC_OFF && !oc_q
    |=> !oc_q)
    else $error("disabled mode reported overcurrent");
  clr_keeps_a: assert property (clr_cmd && s_tsd |=> ots_q)
    else $error("clear dropped a present fault");
  otw_gate_a: assert property (!thermal_warning_report_enable && !otw_q |=> !otw_q)
    else $error("warning reported while disabled");
  sat_pin_a: assert property (sat_act |=> !fault_out_n)
    else $error("saturation not on fault pin");

  cover_retry_c: cover property (oc_st_q == MDFR_OC_WAIT ##1
    oc_st_q == MDFR_OC_RUN);
  cover_latch_c: cover property (oc_st_q == MDFR_OC_HOLD ##1
    oc_st_q == MDFR_OC_RUN);
  cover_tsd_c: cover property ($fell(s_tsd) ##[1:20] clr_cmd);

endmodule : mdfr_fault_response
